// File: rtl/legacy_bios_region_steering.sv
// attribute decode and cycle steering for bios segments 0c8000h-0dffffh
`timescale 1ns/100ps

// Notes on behaviour
// - register at 92h covers 0c8000h-0cffffh; its upper field is nominally reserved
// - 92h bits 1:0 steer cycles to 0c8000-0cbfff
// - 93h bits 5:4 steer cycles to 0d4000-0d7fff
// - 93h bits 1:0 steer cycles to 0d0000-0d3fff
// - 94h bits 5:4 steer cycles to 0dc000-0dffff
// - 94h bits 1:0 steer cycles to 0d8000-0dbfff
// - field 00: all reads and writes go down the hub link
// - field 01: reads from dram, writes down the hub link
// - field 10: writes to dram, reads down the hub link
// - field 11: reads and writes both go to dram
// - in trusted execution lock mode all fields are read-only
// - hub link or graphics accesses to whole region go to dram
module legacy_bios_region_steering import bios_steer_pkg::*; (
    input  wire logic     clock_i,
    input  wire logic     sys_rst_i,
    input  wire cfg_req_s cfg_i,
    input  wire logic     trusted_execution_lock_mode_i,
    input  wire cycle_s   cyc_i,
    output route_s        route_o,
    output logic [7:0]    cfg_rdata_o,
    output logic          cfg_rvalid_o,
    output logic          peer_attr_fault_o
);

    // register instances
    logic [7:0] attr_c8_cf;
    logic [7:0] attr_d0_d7;
    logic [7:0] attr_d8_df;
    logic       sel_c8_cf;
    logic       sel_d0_d7;
    logic       sel_d8_df;

    segment_attr_reg #(
        .OFFSET (ATTR_C8_CF_OFS)
    ) u_attr_c8_cf (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .cfg_i     (cfg_i),
        .lock_i    (trusted_execution_lock_mode_i),
        .attr_o    (attr_c8_cf),
        .sel_o     (sel_c8_cf)
    );

    segment_attr_reg #(
        .OFFSET (ATTR_D0_D7_OFS)
    ) u_attr_d0_d7 (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .cfg_i     (cfg_i),
        .lock_i    (trusted_execution_lock_mode_i),
        .attr_o    (attr_d0_d7),
        .sel_o     (sel_d0_d7)
    );

    segment_attr_reg #(
        .OFFSET (ATTR_D8_DF_OFS)
    ) u_attr_d8_df (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .cfg_i     (cfg_i),
        .lock_i    (trusted_execution_lock_mode_i),
        .attr_o    (attr_d8_df),
        .sel_o     (sel_d8_df)
    );

    // per-segment fields
    logic [1:0] f_c8;
    logic [1:0] f_cc;
    logic [1:0] f_d0;
    logic [1:0] f_d4;
    logic [1:0] f_d8;
    logic [1:0] f_dc;

    assign f_c8 = attr_c8_cf[LO_FIELD_LSB +: FIELD_W];
    // upper field kept functional: encodings are listed for it
    assign f_cc = attr_c8_cf[HI_FIELD_LSB +: FIELD_W];
    assign f_d0 = attr_d0_d7[LO_FIELD_LSB +: FIELD_W];
    assign f_d4 = attr_d0_d7[HI_FIELD_LSB +: FIELD_W];
    assign f_d8 = attr_d8_df[LO_FIELD_LSB +: FIELD_W];
    assign f_dc = attr_d8_df[HI_FIELD_LSB +: FIELD_W];

    // address decode
    logic [SEG_NUM_W-1:0] seg_num;
    logic [REGION_W-1:0]  region_num;
    logic                 hit_c8;
    logic                 hit_cc;
    logic                 hit_d0;
    logic                 hit_d4;
    logic                 hit_d8;
    logic                 hit_dc;
    logic                 seg_hit;
    logic                 in_region;

    assign seg_num    = cyc_i.addr[ADDR_W-1:SEG_SHIFT];
    assign region_num = cyc_i.addr[ADDR_W-1:REGION_SHIFT];
    assign hit_c8     = (seg_num == SEG_C8);
    assign hit_cc     = (seg_num == SEG_CC);
    assign hit_d0     = (seg_num == SEG_D0);
    assign hit_d4     = (seg_num == SEG_D4);
    assign hit_d8     = (seg_num == SEG_D8);
    assign hit_dc     = (seg_num == SEG_DC);
    assign seg_hit    = hit_c8 | hit_cc | hit_d0 | hit_d4 | hit_d8 | hit_dc;
    assign in_region  = (region_num == REGION_IDX);

    logic [1:0] field_sel;
    logic [2:0] seg_code;

    assign field_sel = hit_c8 ? f_c8 :
                       hit_cc ? f_cc :
                       hit_d0 ? f_d0 :
                       hit_d4 ? f_d4 :
                       hit_d8 ? f_d8 :
                       hit_dc ? f_dc : ATTR_HUB_ONLY;

    assign seg_code  = hit_c8 ? SEGCODE_C8 :
                       hit_cc ? SEGCODE_CC :
                       hit_d0 ? SEGCODE_D0 :
                       hit_d4 ? SEGCODE_D4 :
                       hit_d8 ? SEGCODE_D8 :
                       hit_dc ? SEGCODE_DC : SEGCODE_NONE;

    // steering decision
    logic   is_host;
    logic   peer_hit;
    logic   host_hit;
    logic   dram_sel;
    logic   peer_fault;
    route_s route_r;
    route_s route_nxt;

    assign is_host  = (cyc_i.src == SRC_HOST);
    // peers bypass the attribute fields for the whole region
    assign peer_hit = cyc_i.valid && !is_host && in_region;
    // other segments of the region belong to neighbouring decoders
    assign host_hit = cyc_i.valid && is_host && seg_hit;
    // one bit per direction covers all four encodings
    assign dram_sel = cyc_i.write ? field_sel[WR_DRAM_BIT] : field_sel[RD_DRAM_BIT];

    // a peer access to a segment not fully in dram may hang the far side
    assign peer_fault = peer_hit && seg_hit && (field_sel != ATTR_ALL_DRAM);

    assign route_nxt.valid   = cyc_i.valid;
    assign route_nxt.claimed = peer_hit || host_hit;
    assign route_nxt.to_dram = peer_hit || (host_hit && dram_sel);
    assign route_nxt.to_hub  = host_hit && !dram_sel;
    assign route_nxt.write   = cyc_i.write;
    assign route_nxt.seg     = seg_code;

    // configuration read path
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic [7:0] rd_mux;

    assign rd_mux = sel_c8_cf ? attr_c8_cf :
                    sel_d0_d7 ? attr_d0_d7 :
                    sel_d8_df ? attr_d8_df : UNMAPPED_RDATA;
    // reserved bits are held at zero inside each register
    assign rdata_nxt = cfg_i.rd ? rd_mux : rdata_r;

    logic fault_r;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            route_r  <= '0;
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
            fault_r  <= 1'b0;
        end else begin
            route_r  <= route_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= cfg_i.rd;
            fault_r  <= peer_fault;
        end
    end

    assign route_o           = route_r;
    assign cfg_rdata_o       = rdata_r;
    assign cfg_rvalid_o      = rvalid_r;
    assign peer_attr_fault_o = fault_r;

    // checks
    logic host_seg;

    assign host_seg = cyc_i.valid && is_host && seg_hit;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_hub_only_field: assert property (
        host_seg && field_sel == ATTR_HUB_ONLY
        |=> route_r.to_hub && !route_r.to_dram && route_r.claimed)
        else $error("field 00 cycle not sent to hub link");

    a_read_only_field: assert property (
        host_seg && field_sel == ATTR_READ_DRAM
        |=> route_r.to_dram == !route_r.write && route_r.to_hub == route_r.write)
        else $error("field 01 cycle misrouted");

    a_write_only_field: assert property (
        host_seg && field_sel == ATTR_WRITE_DRAM
        |=> route_r.to_dram == route_r.write && route_r.to_hub == !route_r.write)
        else $error("field 10 cycle misrouted");

    a_all_dram_field: assert property (
        host_seg && field_sel == ATTR_ALL_DRAM
        |=> route_r.to_dram && !route_r.to_hub)
        else $error("field 11 cycle not sent to dram");

    a_peer_to_dram: assert property (
        cyc_i.valid && !is_host && cyc_i.addr[ADDR_W-1:REGION_SHIFT] == REGION_IDX
        |=> route_r.to_dram && !route_r.to_hub && route_r.claimed)
        else $error("peer region access not sent to dram");

    a_c8_low_steer: assert property (
        cyc_i.valid && is_host && cyc_i.addr[ADDR_W-1:SEG_SHIFT] == SEG_C8 && !cyc_i.write
        |=> route_r.to_dram == $past(attr_c8_cf[0]) && route_r.seg == SEGCODE_C8)
        else $error("0c8000 read not steered by 92h bits 1:0");

    a_d4_high_steer: assert property (
        cyc_i.valid && is_host && cyc_i.addr[ADDR_W-1:SEG_SHIFT] == SEG_D4 && cyc_i.write
        |=> route_r.to_dram == $past(attr_d0_d7[5]))
        else $error("0d4000 write not steered by 93h bits 5:4");

    a_d0_low_steer: assert property (
        cyc_i.valid && is_host && cyc_i.addr[ADDR_W-1:SEG_SHIFT] == SEG_D0 && cyc_i.write
        |=> route_r.to_dram == $past(attr_d0_d7[1]))
        else $error("0d0000 write not steered by 93h bits 1:0");

    a_dc_high_steer: assert property (
        cyc_i.valid && is_host && cyc_i.addr[ADDR_W-1:SEG_SHIFT] == SEG_DC && !cyc_i.write
        |=> route_r.to_dram == $past(attr_d8_df[4]))
        else $error("0dc000 read not steered by 94h bits 5:4");

    a_d8_low_steer: assert property (
        cyc_i.valid && is_host && cyc_i.addr[ADDR_W-1:SEG_SHIFT] == SEG_D8 && !cyc_i.write
        |=> route_r.to_dram == $past(attr_d8_df[0]))
        else $error("0d8000 read not steered by 94h bits 1:0");

    a_cc_upper_steer: assert property (
        cyc_i.valid && is_host && cyc_i.addr[ADDR_W-1:SEG_SHIFT] == SEG_CC && cyc_i.write
        |=> route_r.to_dram == $past(attr_c8_cf[5]))
        else $error("0cc000 write not steered by 92h bits 5:4");

    a_rdata_reserved_zero: assert property (
        cfg_i.rd |=> cfg_rvalid_o && cfg_rdata_o[7:6] == 2'h0 && cfg_rdata_o[3:2] == 2'h0)
        else $error("reserved bits read nonzero");

    a_locked_readback: assert property (
        trusted_execution_lock_mode_i && cfg_i.wr && cfg_i.addr == ATTR_D0_D7_OFS
        ##[1:2] cfg_i.rd && cfg_i.addr == ATTR_D0_D7_OFS
        |=> cfg_rdata_o == $past(attr_d0_d7, 2))
        else $error("locked write changed readback");

    a_peer_fault_flag: assert property (
        peer_hit && seg_hit && field_sel != ATTR_ALL_DRAM |=> peer_attr_fault_o)
        else $error("unsafe peer access not flagged");

    a_peer_fault_quiet: assert property (
        !(peer_hit && seg_hit && field_sel != ATTR_ALL_DRAM) |=> !peer_attr_fault_o)
        else $error("peer fault flag raised without cause");

    a_lock_fields_stable: assert property (
        trusted_execution_lock_mode_i |=> $stable(attr_c8_cf) && $stable(attr_d0_d7) && $stable(attr_d8_df))
        else $error("attribute field changed in lock mode");

    a_peer_outside_free: assert property (
        cyc_i.valid && !is_host && !in_region
        |=> !route_r.claimed && !route_r.to_dram && !route_r.to_hub)
        else $error("peer access outside region claimed");

    // neighbouring decoders own the rest of the legacy region
    a_host_outside_free: assert property (
        cyc_i.valid && is_host && !seg_hit
        |=> !route_r.claimed && !route_r.to_dram && !route_r.to_hub)
        else $error("host access outside segments claimed");

    a_one_destination: assert property (
        route_r.claimed |-> route_r.to_dram != route_r.to_hub)
        else $error("claimed cycle has no single destination");

    a_route_mirrors_valid: assert property (
        cyc_i.valid |=> route_r.valid && route_r.write == $past(cyc_i.write))
        else $error("routed cycle does not mirror request");

    a_route_idle_quiet: assert property (
        !cyc_i.valid |=> !route_r.valid && !route_r.claimed)
        else $error("route output active without request");

    a_rvalid_single: assert property (
        !cfg_i.rd |=> !cfg_rvalid_o)
        else $error("read valid without read strobe");

    a_rdata_holds: assert property (
        !cfg_i.rd |=> $stable(cfg_rdata_o))
        else $error("read data changed without read");

    a_unmapped_read_zero: assert property (
        cfg_i.rd && !sel_c8_cf && !sel_d0_d7 && !sel_d8_df |=> cfg_rdata_o == UNMAPPED_RDATA)
        else $error("unmapped offset read nonzero");

    // reset must clear outputs whatever the bus is doing
    a_reset_clears_out: assert property (disable iff (1'b0)
        sys_rst_i |=> route_r == '0 && !rvalid_r && !fault_r && rdata_r == 8'h00)
        else $error("outputs not cleared by reset");

    c_host_to_hub: cover property (host_seg && !dram_sel ##1 route_r.to_hub);
    c_host_to_dram: cover property (host_seg && dram_sel ##1 route_r.to_dram);
    c_locked_write: cover property (trusted_execution_lock_mode_i && cfg_i.wr && cfg_i.addr == ATTR_C8_CF_OFS);
    c_peer_access: cover property (peer_hit ##1 route_r.to_dram);

endmodule

// File: rtl/bios_steer_pkg.sv
// constants and carrier types for legacy bios segment steering
package bios_steer_pkg;

    // configuration offsets of the three attribute registers
    localparam logic [7:0] ATTR_C8_CF_OFS = 8'h92;
    localparam logic [7:0] ATTR_D0_D7_OFS = 8'h93;
    localparam logic [7:0] ATTR_D8_DF_OFS = 8'h94;

    // register reset value and writable bits
    localparam logic [7:0] ATTR_RESET      = 8'h00;
    localparam logic [7:0] ATTR_WRITE_MASK = 8'h33;
    localparam logic [7:0] UNMAPPED_RDATA  = 8'h00;

    // field positions inside each attribute register
    localparam int LO_FIELD_LSB = 0;
    localparam int HI_FIELD_LSB = 4;
    localparam int FIELD_W      = 2;

    // attribute encodings; bit 0 sends reads to dram, bit 1 writes
    localparam logic [1:0] ATTR_HUB_ONLY   = 2'h0;
    localparam logic [1:0] ATTR_READ_DRAM  = 2'h1;
    localparam logic [1:0] ATTR_WRITE_DRAM = 2'h2;
    localparam logic [1:0] ATTR_ALL_DRAM   = 2'h3;
    localparam int         RD_DRAM_BIT     = 0;
    localparam int         WR_DRAM_BIT     = 1;

    // address layout: 16 KB segments, 256 KB legacy region
    localparam int          ADDR_W       = 32;
    localparam int          SEG_SHIFT    = 14;
    localparam int          SEG_NUM_W    = ADDR_W - SEG_SHIFT;
    localparam int          REGION_SHIFT = 18;
    localparam int          REGION_W     = ADDR_W - REGION_SHIFT;
    localparam logic [13:0] REGION_IDX   = 14'h0003;
    localparam logic [17:0] SEG_C8       = 18'h00032;
    localparam logic [17:0] SEG_CC       = 18'h00033;
    localparam logic [17:0] SEG_D0       = 18'h00034;
    localparam logic [17:0] SEG_D4       = 18'h00035;
    localparam logic [17:0] SEG_D8       = 18'h00036;
    localparam logic [17:0] SEG_DC       = 18'h00037;

    // segment codes reported with each routed cycle
    localparam logic [2:0] SEGCODE_NONE = 3'h0;
    localparam logic [2:0] SEGCODE_C8   = 3'h1;
    localparam logic [2:0] SEGCODE_CC   = 3'h2;
    localparam logic [2:0] SEGCODE_D0   = 3'h3;
    localparam logic [2:0] SEGCODE_D4   = 3'h4;
    localparam logic [2:0] SEGCODE_D8   = 3'h5;
    localparam logic [2:0] SEGCODE_DC   = 3'h6;

    // origin of a memory cycle
    typedef enum logic [2:0] {
        SRC_HOST = 3'b001,
        SRC_HUB  = 3'b010,
        SRC_GFX  = 3'b100
    } src_e;

    typedef struct packed {
        logic              valid;
        logic              write;
        src_e              src;
        logic [ADDR_W-1:0] addr;
    } cycle_s;

    typedef struct packed {
        logic       valid;
        logic       claimed;
        logic       to_dram;
        logic       to_hub;
        logic       write;
        logic [2:0] seg;
    } route_s;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_req_s;

endpackage

// File: rtl/segment_attr_reg.sv
// one lockable attribute register holding two segment fields
`timescale 1ns/100ps
module segment_attr_reg import bios_steer_pkg::*; #(
    parameter logic [7:0] OFFSET = ATTR_C8_CF_OFS
) (
    input  wire logic     clock_i,
    input  wire logic     sys_rst_i,
    input  wire cfg_req_s cfg_i,
    input  wire logic     lock_i,
    output logic [7:0]    attr_o,
    output logic          sel_o
);

    logic [7:0] attr_r;
    logic [7:0] attr_nxt;
    logic       wr_take;

    assign sel_o    = (cfg_i.addr == OFFSET);
    // lock mode turns every writable field read-only
    assign wr_take  = cfg_i.wr && sel_o && !lock_i;
    // reserved bits never take a written one
    assign attr_nxt = wr_take ? (cfg_i.wdata & ATTR_WRITE_MASK) : attr_r;
    assign attr_o   = attr_r;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            attr_r <= ATTR_RESET;
        end else begin
            attr_r <= attr_nxt;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_lock_holds_attr: assert property (
        cfg_i.wr && sel_o && lock_i |=> attr_r == $past(attr_r))
        else $error("attribute changed while locked");

    a_write_lands_masked: assert property (
        cfg_i.wr && sel_o && !lock_i |=> attr_r == ($past(cfg_i.wdata) & ATTR_WRITE_MASK))
        else $error("unlocked write not stored masked");

    a_reserved_stay_zero: assert property (
        (attr_r & ~ATTR_WRITE_MASK) == 8'h00)
        else $error("reserved attribute bit set");

endmodule

// File: verification/cycle_source.sv
// host and hub side memory cycle source for the steering block
`timescale 1ns/100ps
module cycle_source import bios_steer_pkg::*; (
    input  wire logic clock_i,
    output cycle_s    cyc_o
);
    initial begin
        cyc_o = '0;
    end
    // peers go only to segments set 11, unless a test wants the fault flag
    task automatic issue(input logic wr, input src_e src, input logic [ADDR_W-1:0] addr);
        @(negedge clock_i);
        cyc_o = '{valid: 1'b1, write: wr, src: src, addr: addr};
        @(negedge clock_i);
        // released bus carries no stale address
        cyc_o = '{valid: 1'b0, write: ~wr, src: src, addr: ~addr};
    endtask
endmodule

// File: verification/legacy_bios_region_steering_tb.sv
// self-checking bench for legacy bios segment steering
`timescale 1ns/100ps
module legacy_bios_region_steering_tb;
    import bios_steer_pkg::*;
    logic              clock_i;
    logic              sys_rst_i;
    cfg_req_s          cfg_i;
    logic              lock_i;
    cycle_s            cyc_i;
    route_s            route_o;
    logic [7:0]        cfg_rdata_o;
    logic              cfg_rvalid_o;
    logic              peer_attr_fault_o;
    int                n_errors;
    int                num_checks;
    logic [1:0]        code;
    logic [1:0]        fld;
    logic [ADDR_W-1:0] seg_addr [6];

    legacy_bios_region_steering u_legacy_bios_region_steering (
        .clock_i                       (clock_i),
        .sys_rst_i                     (sys_rst_i),
        .cfg_i                         (cfg_i),
        .trusted_execution_lock_mode_i (lock_i),
        .cyc_i                         (cyc_i),
        .route_o                       (route_o),
        .cfg_rdata_o                   (cfg_rdata_o),
        .cfg_rvalid_o                  (cfg_rvalid_o),
        .peer_attr_fault_o             (peer_attr_fault_o)
    );

    cycle_source u_cycle_source (
        .clock_i (clock_i),
        .cyc_o   (cyc_i)
    );

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cfg_wr(input logic [7:0] ofs, input logic [7:0] data);
        @(negedge clock_i);
        cfg_i = '{rd: 1'b0, wr: 1'b1, addr: ofs, wdata: data};
        @(negedge clock_i);
        cfg_i = '{rd: 1'b0, wr: 1'b0, addr: ~ofs, wdata: ~data};
    endtask

    task automatic cfg_rd(input logic [7:0] ofs, input logic [7:0] exp);
        @(negedge clock_i);
        cfg_i = '{rd: 1'b1, wr: 1'b0, addr: ofs, wdata: 8'h00};
        @(negedge clock_i);
        cfg_i = '{rd: 1'b0, wr: 1'b0, addr: ~ofs, wdata: 8'hff};
        check("rvalid", 8'h01, {7'h00, cfg_rvalid_o});
        check("rdata", exp, cfg_rdata_o);
    endtask

    task automatic cyc_chk(input logic wr, input src_e src, input logic [ADDR_W-1:0] addr,
                           input logic claim, input logic dram, input logic [2:0] seg, input logic flt);
        route_s e;
        e = '{valid: 1'b1, claimed: claim, to_dram: dram, to_hub: claim & ~dram, write: wr, seg: seg};
        u_cycle_source.issue(wr, src, addr);
        check("route", e, route_o);
        check("fault", {7'h00, flt}, {7'h00, peer_attr_fault_o});
    endtask

    // hang guard, well above the under two hundred cycles the tests take
    initial begin
        #40000;
        n_errors++;
        print_verdict();
    end

    initial begin
        n_errors = 0;
        num_checks = 0;
        cfg_i = '0;
        lock_i = 1'b0;
        sys_rst_i = 1'b1;
        // lo segments at base, hi segments at last byte, to hit both edges
        seg_addr = '{32'h000c8000, 32'h000cffff, 32'h000d0000, 32'h000d7fff, 32'h000d8000, 32'h000dffff};
        repeat (5) @(negedge clock_i);
        sys_rst_i = 1'b0;
        check("route after reset", 8'h00, route_o);
        check("rvalid after reset", 8'h00, {7'h00, cfg_rvalid_o});
        for (int r = 0; r < 3; r++) begin
            cfg_rd(ATTR_C8_CF_OFS + r[7:0], 8'h00);
        end
        cfg_rd(8'h95, 8'h00);
        cyc_chk(1'b0, SRC_HOST, 32'h000c8000, 1'b1, 1'b0, SEGCODE_C8, 1'b0);
        // hi field gets the inverse code so a swapped field shows up
        for (int c = 0; c < 4; c++) begin
            code = c[1:0];
            for (int r = 0; r < 3; r++) begin
                cfg_wr(ATTR_C8_CF_OFS + r[7:0], {2'b11, ~code, 2'b11, code});
                cfg_rd(ATTR_C8_CF_OFS + r[7:0], {2'b00, ~code, 2'b00, code});
            end
            for (int i = 0; i < 6; i++) begin
                fld = i[0] ? ~code : code;
                for (int w = 0; w < 2; w++) begin
                    cyc_chk(w[0], SRC_HOST, seg_addr[i], 1'b1, fld[w], i[2:0] + 3'h1, 1'b0);
                end
            end
        end
        // now 92h, 93h and 94h all hold 03
        lock_i = 1'b1;
        cfg_wr(ATTR_D0_D7_OFS, 8'h30);
        cfg_rd(ATTR_D0_D7_OFS, 8'h03);
        cyc_chk(1'b1, SRC_HOST, 32'h000d4000, 1'b1, 1'b0, SEGCODE_D4, 1'b0);
        lock_i = 1'b0;
        cfg_wr(ATTR_D0_D7_OFS, 8'h30);
        cfg_rd(ATTR_D0_D7_OFS, 8'h30);
        cfg_wr(8'h91, 8'hff);
        cfg_rd(ATTR_C8_CF_OFS, 8'h03);
        cyc_chk(1'b0, SRC_HUB, 32'h000c8000, 1'b1, 1'b1, SEGCODE_C8, 1'b0);
        cyc_chk(1'b1, SRC_GFX, 32'h000d0000, 1'b1, 1'b1, SEGCODE_D0, 1'b1);
        cyc_chk(1'b0, SRC_HUB, 32'h000f0000, 1'b1, 1'b1, SEGCODE_NONE, 1'b0);
        cyc_chk(1'b1, SRC_GFX, 32'h00100000, 1'b0, 1'b0, SEGCODE_NONE, 1'b0);
        cyc_chk(1'b0, SRC_HOST, 32'h000c4000, 1'b0, 1'b0, SEGCODE_NONE, 1'b0);
        cyc_chk(1'b1, SRC_HOST, 32'h000e0000, 1'b0, 1'b0, SEGCODE_NONE, 1'b0);
        // second reset in mid-run clears the fields again
        @(negedge clock_i);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        sys_rst_i = 1'b0;
        check("route after reset", 8'h00, route_o);
        cfg_rd(ATTR_D0_D7_OFS, 8'h00);
        cyc_chk(1'b1, SRC_HOST, 32'h000dc000, 1'b1, 1'b0, SEGCODE_DC, 1'b0);
        print_verdict();
    end
endmodule
